//--- hdl/itu_unit.v
/*
  Interrupt and trap unit: edge detect on the external pin, timer event
  latching, enable gating, acknowledge sequencer with stack push and vector,
  return sequencer, undefined memory fill, and an AHB-Lite register slave.
  Assumes hclk is the instruction-cycle clock, the core pulses its strobes for
  one cycle at instruction boundaries, and the stack RAM accepts one byte a cycle.
*/
// The AHB-Lite slave port and the address map were left to the implementer.
`timescale 1ns/10ps
`include "itu_defs.vh"

module itu_unit (
  // Clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // AHB-Lite slave port
  input  wire        hsel,
  input  wire [7:0]  haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  // External pin and timer events
  input  wire        ext_irq_pin,
  input  wire        timer_underflow,
  input  wire        timer_capture,
  // Core sequencer handshake
  input  wire        insn_boundary,
  input  wire [7:0]  opcode,
  input  wire        ret_plain,
  input  wire        ret_skip,
  input  wire        ret_irq,
  input  wire [14:0] pc_in,
  // Memory fill paths
  input  wire [7:0]  prog_raw,
  input  wire        prog_defined,
  output wire [7:0]  prog_data,
  input  wire [7:0]  data_raw,
  input  wire        data_defined,
  output wire [7:0]  data_rd,
  // Stack RAM port
  output reg  [7:0]  stack_addr,
  output reg  [7:0]  stack_wdata,
  output reg         stack_we,
  input  wire [7:0]  stack_rdata,
  // Program counter redirect
  output reg  [14:0] pc_load,
  output reg         pc_load_en,
  output reg         skip_next,
  output wire        core_stall
);

  // Sequencer states, one-hot
  // IDLE waits for a boundary, ACK and RET run their counts, DONE is one spare cycle
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_ACK  = 4'b0010;
  localparam [3:0] ST_RET  = 4'b0100;
  localparam [3:0] ST_DONE = 4'b1000;

  // Register state
  // Everything below is cleared or preset by the asynchronous reset
  reg        gie_reg;         // Global enable
  reg        eni_reg;         // External enable
  reg        timer_irq_enable_reg;        // Timer enable
  reg        ext_irq_pending_reg;        // External pending
  reg        timer_irq_pending_reg;        // Timer pending
  reg        edge_sel_reg;    // Edge select
  reg  [7:0] sp_reg;          // Stack pointer
  reg  [3:0] state_reg;       // Sequencer state
  reg  [2:0] cnt_reg;         // Cycle count in sequence
  reg        ret_gie_reg;     // Return sets global enable
  reg        ret_skip_reg;    // Return skips next
  reg  [6:0] pop_hi_reg;      // Popped upper byte
  reg  [14:0] pc_save_reg;    // PC being pushed

  // Pin synchroniser and edge history
  reg        pin_s1_reg;      // First stage, read only by the second
  reg        pin_s2_reg;      // Second stage, safe for logic
  reg        pin_d_reg;       // One cycle of history for the edge test
  reg  [2:0] prime_reg;       // Fills with ones once the history holds real samples

  // Bus data phase capture
  reg        bus_wr_reg;
  reg  [7:0] bus_addr_reg;
  reg [31:0] rdata_reg;

  // Derived combinational terms
  wire       ext_edge;
  wire       bus_take;
  wire       bus_wr_now;
  wire       psw_wr;
  wire       ctrl_wr;
  wire       sp_wr;
  wire       trap_hit;
  wire       hw_req;
  wire [7:0] psw_val;
  wire [7:0] ctrl_val;

  // Word select helper for decode used in two places
  // Compares word addresses, ignoring the byte lane bits
  function sel_word;
    input [7:0] a;
    input [7:0] b;
    begin
      sel_word = (a[7:2] == b[7:2]);
    end
  endfunction

  // Two-flop synchroniser on the pin, then history for edges.
  // The pin may sit high through reset; the primer keeps the cleared
  // history from being mistaken for a rising edge after release.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1_reg <= 1'b0;
      pin_s2_reg <= 1'b0;
      pin_d_reg  <= 1'b0;
      prime_reg  <= 3'b000;
    end else begin
      pin_s1_reg <= ext_irq_pin;
      pin_s2_reg <= pin_s1_reg;
      pin_d_reg  <= pin_s2_reg;
      prime_reg  <= {prime_reg[1:0], 1'b1};
    end
  end

  // Edge of chosen polarity, only once both history flops hold the pin
  assign ext_edge = prime_reg[2] &
                    (edge_sel_reg ? (pin_d_reg & ~pin_s2_reg)
                                  : (~pin_d_reg & pin_s2_reg));

  // Bus address phase accepted
  // Only NONSEQ or SEQ with the bus ready opens a transfer
  assign bus_take   = hsel & hready & htrans[1];
  // Writes act in the data phase, one cycle after the address was taken
  assign bus_wr_now = bus_wr_reg;
  assign psw_wr     = bus_wr_now & sel_word(bus_addr_reg, `ITU_ADDR_PSW);
  assign ctrl_wr    = bus_wr_now & sel_word(bus_addr_reg, `ITU_ADDR_CTRL);
  assign sp_wr      = bus_wr_now & sel_word(bus_addr_reg, `ITU_ADDR_SP);

  // Status and control word images
  // Every flag sits at its word bit; unused bits read zero
  assign psw_val  = {2'b00, timer_irq_pending_reg, timer_irq_enable_reg, ext_irq_pending_reg, 1'b0, eni_reg, gie_reg};
  assign ctrl_val = {5'b00000, edge_sel_reg, 2'b00};

  // Trap on opcode zero at a boundary, ignores every enable
  assign trap_hit = insn_boundary & (opcode == `ITU_TRAP_OPCODE);
  // A request that arrives mid-sequence waits for the next boundary
  // Maskable request, gated globally and per source
  assign hw_req   = insn_boundary & gie_reg &
                    ((eni_reg & ext_irq_pending_reg) | (timer_irq_enable_reg & timer_irq_pending_reg));

  // Bus address phase capture
  // Only the write flag and the address are kept; hwdata is read live later
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_wr_reg   <= 1'b0;
      bus_addr_reg <= 8'h00;
    end else begin
      bus_wr_reg   <= bus_take & hwrite;
      if (bus_take) begin
        bus_addr_reg <= haddr;
      end
    end
  end

  // Read data register, updated in the address phase
  // Values are those of the address cycle; the data phase just presents them
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_reg <= 32'h0000_0000;
    end else if (bus_take & ~hwrite) begin
      if (sel_word(haddr, `ITU_ADDR_PSW)) begin
        rdata_reg <= {24'h00_0000, psw_val};
      end else if (sel_word(haddr, `ITU_ADDR_CTRL)) begin
        rdata_reg <= {24'h00_0000, ctrl_val};
      end else if (sel_word(haddr, `ITU_ADDR_SP)) begin
        // Stack pointer and last pushed PC are read back for software
        rdata_reg <= {24'h00_0000, sp_reg};
      end else if (sel_word(haddr, `ITU_ADDR_PC)) begin
        rdata_reg <= {17'h0_0000, pc_save_reg};
      end else begin
        // Unmapped reads zero
        rdata_reg <= 32'h0000_0000;
      end
    end
  end

  // Zero wait states and an OKAY answer on every transfer
  assign hrdata    = rdata_reg;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Pending flags: hardware set wins over software clear
  // A clear that meets a new event in the same cycle loses, so no edge is lost
  // Acknowledge never touches these; software owns the clear
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_irq_pending_reg <= 1'b0;
      timer_irq_pending_reg <= 1'b0;
    end else begin
      if (ext_edge) begin
        ext_irq_pending_reg <= 1'b1;
      end else if (psw_wr) begin
        ext_irq_pending_reg <= hwdata[`ITU_PSW_EXT_IRQ_PENDING];
      end
      if (timer_underflow | timer_capture) begin
        timer_irq_pending_reg <= 1'b1;
      end else if (psw_wr) begin
        timer_irq_pending_reg <= hwdata[`ITU_PSW_TIMER_IRQ_PENDING];
      end
    end
  end

  // Enables and edge select
  // Hardware clear beats a return, which beats a software write in one cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gie_reg      <= `ITU_RST_GIE;
      eni_reg      <= 1'b0;
      timer_irq_enable_reg     <= 1'b0;
      edge_sel_reg <= 1'b0;
    end else begin
      if (state_reg == ST_IDLE && hw_req) begin
        gie_reg <= 1'b0;
      end else if (state_reg == ST_DONE && ret_gie_reg) begin
        gie_reg <= 1'b1;
      end else if (psw_wr) begin
        gie_reg <= hwdata[`ITU_PSW_GIE];
      end
      // Per-source enables change only by software
      if (psw_wr) begin
        eni_reg  <= hwdata[`ITU_PSW_ENI];
        timer_irq_enable_reg <= hwdata[`ITU_PSW_TIMER_IRQ_ENABLE];
      end
      // Edge select is the only live bit of the control word
      if (ctrl_wr) begin
        edge_sel_reg <= hwdata[`ITU_CTRL_EDGE];
      end
    end
  end

  // Acknowledge and return sequencer
  // ACK pushes and vectors, RET pops, DONE lets a return restore the enable
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg    <= ST_IDLE;
      cnt_reg      <= 3'd0;
      sp_reg       <= `ITU_RST_SP;
      ret_gie_reg  <= 1'b0;
      ret_skip_reg <= 1'b0;
      pop_hi_reg   <= 7'h00;
      pc_save_reg  <= `ITU_RST_PC;
      stack_addr   <= 8'h00;
      stack_wdata  <= 8'h00;
      stack_we     <= 1'b0;
      pc_load      <= `ITU_RST_PC;
      pc_load_en   <= 1'b0;
      skip_next    <= 1'b0;
    end else begin
      // Strobes are one-cycle pulses unless a branch raises them
      stack_we   <= 1'b0;
      pc_load_en <= 1'b0;
      skip_next  <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          // Stack pointer writes from the bus are taken only while idle
          if (sp_wr) begin
            sp_reg <= hwdata[7:0];
          end
          if (hw_req | trap_hit) begin
            // Hardware request first; trap keeps global enable
            state_reg   <= ST_ACK;
            pc_save_reg <= pc_in;
            cnt_reg     <= 3'd0;
          end else if (insn_boundary & (ret_plain | ret_skip | ret_irq)) begin
            // Returns start only when no request or trap claims the boundary
            state_reg    <= ST_RET;
            ret_gie_reg  <= ret_irq;
            ret_skip_reg <= ret_skip;
            cnt_reg      <= 3'd0;
          end
        end
        ST_ACK: begin
          cnt_reg <= cnt_reg + 3'd1;
          // Push low byte then high byte, stack grows down
          // Counts two to five only stretch the sequence to its full length
          if (cnt_reg == 3'd0) begin
            stack_addr  <= sp_reg;
            stack_wdata <= pc_save_reg[7:0];
            stack_we    <= 1'b1;
            sp_reg      <= sp_reg - 8'h01;
          end else if (cnt_reg == 3'd1) begin
            stack_addr  <= sp_reg;
            stack_wdata <= {1'b0, pc_save_reg[14:8]};
            stack_we    <= 1'b1;
            sp_reg      <= sp_reg - 8'h01;
          end else if (cnt_reg == `ITU_ACK_LAST) begin
            // Last count: redirect the core to the vector and release it
            pc_load    <= `ITU_VECTOR;
            pc_load_en <= 1'b1;
            state_reg  <= ST_IDLE;
          end
        end
        ST_RET: begin
          cnt_reg <= cnt_reg + 3'd1;
          // Pop high byte then low byte, stack pointer rises; the read port
          // answers in the cycle after the address is registered
          if (cnt_reg == 3'd0) begin
            // Point at the high byte
            stack_addr <= sp_reg + 8'h01;
            sp_reg     <= sp_reg + 8'h01;
          end else if (cnt_reg == 3'd1) begin
            // Keep the high byte now on the port, point at the low byte
            pop_hi_reg <= stack_rdata[6:0];
            stack_addr <= sp_reg + 8'h01;
            sp_reg     <= sp_reg + 8'h01;
          end else if (cnt_reg == 3'd3) begin
            // Low byte still stands on the port; count two only waits
            pc_load    <= {pop_hi_reg, stack_rdata};
            pc_load_en <= 1'b1;
            skip_next  <= ret_skip_reg;
            state_reg  <= ST_DONE;
          end
        end
        ST_DONE: begin
          // One spare cycle in which an interrupt return restores the enable
          state_reg <= ST_IDLE;
        end
        default: begin
          // Unreachable codes fall back to idle
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Core holds while a sequence runs
  // The core must not present a boundary while this is high
  assign core_stall = (state_reg != ST_IDLE);

  // Undefined memory fill values
  // Fills are combinational; the core reads them in the same cycle
  assign prog_data = prog_defined ? prog_raw : `ITU_UNDEF_PROG;
  assign data_rd   = data_defined ? data_raw : `ITU_UNDEF_DATA;

endmodule // itu_unit

//--- hdl/itu_defs.vh
/*
  Constants of the interrupt and trap unit: register addresses, bit positions,
  reset values, vector and timing figures.
  Assumes inclusion by bare name from the design file.
*/
`ifndef ITU_DEFS_VH
`define ITU_DEFS_VH

// Bus register byte addresses
`define ITU_ADDR_CTRL      8'h00
`define ITU_ADDR_PSW       8'h04
`define ITU_ADDR_SP        8'h08
`define ITU_ADDR_PC        8'h0C
// Data addresses of the control and status words in core data space
`define ITU_DADDR_CTRL     8'hEE
`define ITU_DADDR_PSW      8'hEF
// Status word bit positions
`define ITU_PSW_GIE        0
`define ITU_PSW_ENI        1
`define ITU_PSW_EXT_IRQ_PENDING       3
`define ITU_PSW_TIMER_IRQ_ENABLE       4
`define ITU_PSW_TIMER_IRQ_PENDING       5
// Control word bit position
`define ITU_CTRL_EDGE      2
// Reset values
`define ITU_RST_PSW        8'h00
`define ITU_RST_CTRL       8'h00
`define ITU_RST_SP         8'h2F
`define ITU_RST_PC         15'h0000
`define ITU_RST_GIE        1'b0
// Trap opcode, vector, fill values
`define ITU_TRAP_OPCODE    8'h00
`define ITU_VECTOR         15'h00FF
`define ITU_UNDEF_PROG     8'h00
`define ITU_UNDEF_DATA     8'hFF
// Acknowledge length in instruction cycles
`define ITU_ACK_CYCLES     3'd7
`define ITU_ACK_LAST       3'd6

`endif

//--- tb/itu_stack_model.sv
/*
  Stack RAM model beside the unit.
  Assumes one write port and a combinational read.
*/
`timescale 1ns/10ps
module itu_stack_model (
  input  wire       hclk,
  input  wire [7:0] stack_addr,
  input  wire [7:0] stack_wdata,
  input  wire       stack_we,
  output wire [7:0] stack_rdata
);
  logic [7:0] mem [0:255]; // Cells never written read all ones
  initial for (int i = 0; i < 256; i++) mem[i] = 8'hFF;
  // Byte write from the push sequence
  always @(posedge hclk) begin
    if (stack_we === 1'b1) mem[stack_addr] <= stack_wdata;
  end
  assign stack_rdata = mem[stack_addr];
endmodule // itu_stack_model

//--- tb/itu_unit_asserts.sv
/*
  Port assertions for the interrupt and trap unit.
  Assumes binding to itu_unit and one clock domain.
*/
`timescale 1ns/10ps
module itu_unit_asserts (
  input wire        hclk,
  input wire        hresetn,
  input wire        hreadyout,
  input wire        hresp,
  input wire        insn_boundary,
  input wire [7:0]  opcode,
  input wire        ret_plain,
  input wire        ret_skip,
  input wire        ret_irq,
  input wire [7:0]  prog_raw,
  input wire        prog_defined,
  input wire [7:0]  prog_data,
  input wire        data_defined,
  input wire [7:0]  data_rd,
  input wire [7:0]  stack_addr,
  input wire        stack_we,
  input wire [14:0] pc_load,
  input wire        pc_load_en,
  input wire        skip_next,
  input wire        core_stall
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire any_ret = ret_plain | ret_skip | ret_irq; // Any return strobe
  wire trap_b  = insn_boundary & !core_stall & !any_ret & (opcode == 8'h00);
  wire ret_b   = insn_boundary & !core_stall & any_ret;
  // Two pushes to falling addresses
  sequence s_push;
    stack_we ##1 (stack_we && stack_addr == $past(stack_addr) - 8'h01);
  endsequence
  // Load of the fixed vector
  sequence s_vec;
    pc_load_en && pc_load == 15'h00FF && !skip_next;
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not okay");
  a_trap_push: assert property (trap_b |-> ##[1:3] s_push)
    else $error("trap push missing");
  a_trap_vec: assert property (trap_b |-> ##[6:8] s_vec)
    else $error("vector load missing");
  a_ack_len: assert property (trap_b |=> core_stall [*7] ##1 !core_stall)
    else $error("acknowledge length wrong");
  a_ret_skip: assert property (ret_b && ret_skip |-> ##[1:6] (pc_load_en && skip_next))
    else $error("skip return load missing");
  a_ret_nopush: assert property (ret_b |=> !stack_we [*5])
    else $error("return wrote stack");
  a_prog_fill: assert property (prog_data == (prog_defined ? prog_raw : 8'h00))
    else $error("program fill wrong");
  a_data_fill: assert property (!data_defined |-> data_rd == 8'hFF)
    else $error("data fill wrong");
endmodule // itu_unit_asserts
bind itu_unit itu_unit_asserts u_itu_unit_asserts (.hclk, .hresetn, .hreadyout, .hresp,
  .insn_boundary, .opcode, .ret_plain, .ret_skip, .ret_irq, .prog_raw, .prog_defined,
  .prog_data, .data_defined, .data_rd, .stack_addr, .stack_we, .pc_load, .pc_load_en,
  .skip_next, .core_stall);

//--- tb/testbench.sv
/*
  Self-checking bench for the interrupt and trap unit.
  Assumes one hclk domain and the stack model as far side.
*/
`timescale 1ns/10ps
module testbench;
  logic        hclk = 0, hresetn = 0, hwrite = 0, ext_irq_pin = 0;
  logic        timer_underflow = 0, timer_capture = 0, insn_boundary = 0;
  logic        prog_defined = 0, data_defined = 0;
  logic [1:0]  htrans = 0;
  logic [2:0]  rk = 0; // Return kind: plain, skip, irq
  logic [7:0]  haddr = 0, opcode = 8'h01, prog_raw = 0, data_raw = 0;
  logic [14:0] pc_in = 0, pc_seen = 0;
  logic [31:0] hwdata = 0, rd, d, seed = 32'hd677_322f;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, stack_we, pc_load_en, skip_next, core_stall;
  wire  [7:0]  prog_data, data_rd, stack_addr, stack_wdata, stack_rdata;
  wire  [14:0] pc_load;
  integer      err_total = 0, cmp_count = 0;

  always #4 hclk = ~hclk;

  itu_unit u_itu_unit (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .ext_irq_pin,
    .timer_underflow, .timer_capture, .insn_boundary, .opcode, .ret_plain(rk[2]),
    .ret_skip(rk[1]), .ret_irq(rk[0]), .pc_in, .prog_raw, .prog_defined, .prog_data,
    .data_raw, .data_defined, .data_rd, .stack_addr, .stack_wdata, .stack_we, .stack_rdata,
    .pc_load, .pc_load_en, .skip_next, .core_stall);
  itu_stack_model u_itu_stack_model (.hclk, .stack_addr, .stack_wdata, .stack_we,
    .stack_rdata);

  function logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Random memory fill inputs and capture of loaded PC
  always @(posedge hclk) begin
    seed <= lfsr(seed);
    {prog_defined, data_defined} <= seed[1:0];
    prog_raw <= seed[15:8];
    data_raw <= seed[23:16];
    if (pc_load_en === 1'b1) pc_seen <= pc_load;
  end

  task chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // One AHB-Lite single transfer
  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
    @(posedge hclk);
    haddr <= a; hwrite <= w; htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0; hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v); bus(1, a, v, rd); endtask
  task rc(input logic [7:0] a, input logic [31:0] e); bus(0, a, 0, rd); chk(rd, e); endtask

  // One instruction boundary, then wait out the stall
  task insn(input logic [7:0] op, input logic [2:0] k, input logic [14:0] pc);
    integer n;
    n = 0;
    @(posedge hclk);
    insn_boundary <= 1; opcode <= op; rk <= k; pc_in <= pc;
    @(posedge hclk);
    insn_boundary <= 0; rk <= 0; opcode <= 8'h01;
    @(negedge hclk);
    while (core_stall === 1'b1 && n < 20) begin @(negedge hclk); n++; end
  endtask

  task end_sim;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge hclk);
    err_total++;
    end_sim;
  end

  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1;
    rc(8'h04, 0);
    rc(8'h00, 0);
    rc(8'h08, 32'h2F);
    rc(8'h10, 0);
    d = seed; wr(8'h00, d); bus(0, 8'h00, 0, rd);
    chk(rd & 32'h4, d & 32'h4);
    wr(8'h00, 0);
    insn(8'h01, 3'h4, 0); chk(pc_seen, 32'h7FFF);
    wr(8'h08, 32'h2F);
    // Software trap with global enable off, then on
    for (int g = 0; g < 2; g++) begin
      wr(8'h04, g); d = seed; insn(8'h00, 0, d[14:0]);
      rc(8'h08, 32'h2D);
      rc(8'h04, g);
      chk(u_itu_stack_model.mem[8'h2F], d[7:0]);
      chk(u_itu_stack_model.mem[8'h2E], d[14:8]);
      insn(8'h01, 3'h2, 0); chk(pc_seen, d[14:0]);
      rc(8'h08, 32'h2F);
    end
    // External pin: wrong edge ignored, selected edge pends
    for (int s = 0; s < 2; s++) begin
      wr(8'h00, s * 4); ext_irq_pin <= ~s[0]; repeat (4) @(posedge hclk);
      wr(8'h04, 0); ext_irq_pin <= s[0]; repeat (4) @(posedge hclk);
      rc(8'h04, 0);
      ext_irq_pin <= ~s[0]; repeat (4) @(posedge hclk);
      rc(8'h04, 32'h08);
    end
    wr(8'h04, 32'h19); insn(8'h01, 0, 0); rc(8'h08, 32'h2F);
    wr(8'h04, 32'h0B); repeat (3) @(posedge hclk); chk(core_stall, 0);
    insn(8'h01, 0, 15'h0123); rc(8'h04, 32'h0A);
    insn(8'h01, 3'h1, 0); chk(pc_seen, 15'h0123);
    rc(8'h04, 32'h0B);
    insn(8'h01, 0, 0); rc(8'h08, 32'h2D);
    insn(8'h01, 3'h4, 0); rc(8'h08, 32'h2F);
    // Timer underflow and capture
    for (int k = 0; k < 2; k++) begin
      wr(8'h04, 0); {timer_underflow, timer_capture} <= k ? 2'h1 : 2'h2;
      @(posedge hclk); {timer_underflow, timer_capture} <= 0;
      rc(8'h04, 32'h20);
    end
    wr(8'h04, 32'h30); insn(8'h01, 0, 0); rc(8'h08, 32'h2F);
    wr(8'h04, 32'h31); insn(8'h01, 0, 0); rc(8'h04, 32'h30);
    insn(8'h01, 3'h4, 0); rc(8'h08, 32'h2F);
    end_sim;
  end
endmodule // testbench
